// ==== logic/rhpc_pkg.sv ====
// Constants, register map and types for the root hub port change flags
package rhpc_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_TIME_MS = 10;
   localparam int RESUME_TIME_MS = 20;
   localparam int RESYNC_TIME_MS = 3;
   localparam int EOP_TIME_NS = 1334;
   localparam int NS_PER_MS = 1000000;
   localparam int RESET_CYCLES = RESET_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int RESUME_CYCLES = RESUME_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int RESYNC_CYCLES = RESYNC_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int EOP_CYCLES =
      (EOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 19;

   // Register byte offsets
   localparam logic [7:0] FLAGS_OFS = 8'h00;
   localparam logic [7:0] MASK_OFS = 8'h04;
   localparam logic [7:0] CTRL_OFS = 8'h08;
   localparam logic [7:0] STATE_OFS = 8'h0C;

   // Control register bit positions
   localparam int CTRL_START_RESET = 0;
   localparam int CTRL_SUSPEND = 1;
   localparam int CTRL_START_RESUME = 2;
   localparam int CTRL_SET_ENABLE = 3;
   localparam int CTRL_CLEAR_ENABLE = 4;
   localparam int CTRL_PER_PORT_OVC = 5;

   // Reset values
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic PER_PORT_OVC_RESET = 1'b1;

   // AHB transfer types and response
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic HRESP_OKAY = 1'b0;

   // Change flags, also the layout of the mask register
   typedef struct packed {
      logic resetCompleteFlag;
      logic overcurrentChangeFlag;
      logic resumeCompleteFlag;
      logic portEnableChangeFlag;
   } rhpc_flags_t;

   // Port line drive requests toward the transceiver
   typedef struct packed {
      logic resetDrive;
      logic resumeDrive;
      logic eopDrive;
   } rhpc_drive_t;

   typedef enum logic [1:0] {
      RES_IDLE = 2'b00,
      RES_K = 2'b01,
      RES_EOP = 2'b10,
      RES_SYNC = 2'b11
   } rhpc_resume_st_t;
endpackage

// ==== logic/rhpc_port_flags.sv ====
// Root hub port change flags with AHB-Lite register access
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - A hardware disable of the port sets the enable change flag.
// - Software writes that change the port enable leave that flag alone.
// - Writing one to a change flag clears it unless a hardware set comes in the same cycle, and writing zero keeps it.
// - The resume complete flag is set only once the whole resume is over.
// - Resume is a 20 ms resume pulse, a low-speed EOP, then a 3 ms resync.
// - Setting the reset complete flag clears the resume complete flag.
// - The overcurrent change flag only carries meaning in per-port mode.
// - Any change of the overcurrent indicator in per-port mode sets the overcurrent flag.
// - Reset signalling lasts 10 ms and its end sets reset complete.
module rhpc_port_flags #(
   parameter int RESET_LEN = rhpc_pkg::RESET_CYCLES,
   parameter int RESUME_LEN = rhpc_pkg::RESUME_CYCLES,
   parameter int RESYNC_LEN = rhpc_pkg::RESYNC_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Port events and pins
   input wire logic portErrorEvt,
   input wire logic remoteWakeEvt,
   input wire logic overcurrentPin,
   // Port drive and state
   output rhpc_pkg::rhpc_drive_t portDrive,
   output logic portEnabledState,
   output logic portOvercurrentIndicatorA,
   // Interrupt
   output logic irq
);
   import rhpc_pkg::*;

   // Bus pipeline
   logic wrPend_r;
   logic [7:0] wrAddr_r;
   logic addrPhase;
   logic [31:0] rdValue;
   logic wrFlags;
   logic wrMask;
   logic wrCtrl;
   logic [31:0] ctrlWord;
   logic [31:0] stateWord;

   // Register state
   rhpc_flags_t flags_r;
   rhpc_flags_t flags_nxt;
   rhpc_flags_t mask_r;
   rhpc_flags_t setEvt;
   rhpc_flags_t clrReq;
   logic perPortOvc_r;
   logic portEnabled_r;
   logic portSuspended_r;

   // Overcurrent pin synchroniser
   logic ovcMeta_r;
   logic ovcSync_r;
   logic ovcInd_r;

   // Sequencer links
   logic resetStart;
   logic resumeStart;
   logic resetDrive;
   logic resetDone;
   logic resumeDrive;
   logic eopDrive;
   logic resumeBusy;
   logic resumeDone;
   logic hwDisable;
   logic resumeAbort;
   logic ovcRise;
   logic ovcChange;

   // Software commands decoded in the write data phase
   logic swStartReset;
   logic swSuspend;
   logic swStartResume;
   logic swSetEnable;
   logic swClearEnable;

   // Address phase accepted
   assign addrPhase = hsel && hready && htrans[1];
   assign wrFlags = wrPend_r && (wrAddr_r == FLAGS_OFS);
   assign wrMask = wrPend_r && (wrAddr_r == MASK_OFS);
   assign wrCtrl = wrPend_r && (wrAddr_r == CTRL_OFS);

   // Zero wait state: bus is always ready
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end

   // Write address held into data phase
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= '0;
      end else begin
         wrPend_r <= addrPhase && hwrite;
         if (addrPhase) begin
            wrAddr_r <= {haddr[7:2], 2'b00};
         end
      end
   end

   // Read views of the control and state registers
   always_comb begin
      ctrlWord = '0;
      ctrlWord[CTRL_PER_PORT_OVC] = perPortOvc_r;
      ctrlWord[CTRL_SUSPEND] = portSuspended_r;
      stateWord = '0;
      stateWord[0] = portEnabled_r;
      stateWord[1] = portSuspended_r;
      stateWord[2] = resetDrive;
      stateWord[3] = resumeBusy;
      stateWord[4] = ovcInd_r;
   end

   // Read mux, unmapped addresses read zero
   always_comb begin
      rdValue = '0;
      if (haddr[31:8] != 24'h000000) begin
         rdValue = '0;
      end else if (haddr[7:0] == FLAGS_OFS) begin
         rdValue[3:0] = flags_r;
      end else if (haddr[7:0] == MASK_OFS) begin
         rdValue[3:0] = mask_r;
      end else if (haddr[7:0] == CTRL_OFS) begin
         rdValue = ctrlWord;
      end else if (haddr[7:0] == STATE_OFS) begin
         rdValue = stateWord;
      end
   end

   // Read data captured at the address phase
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= '0;
      end else if (addrPhase && !hwrite) begin
         hrdata <= rdValue;
      end
   end

   // Interrupt mask register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_r <= MASK_RESET;
      end else if (wrMask) begin
         mask_r <= hwdata[3:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         perPortOvc_r <= PER_PORT_OVC_RESET;
      end else if (wrCtrl) begin
         perPortOvc_r <= hwdata[CTRL_PER_PORT_OVC];
      end
   end

   // Command strobes from the control register
   assign swStartReset = wrCtrl && hwdata[CTRL_START_RESET];
   assign swSuspend = wrCtrl && hwdata[CTRL_SUSPEND];
   assign swStartResume = wrCtrl && hwdata[CTRL_START_RESUME];
   assign swSetEnable = wrCtrl && hwdata[CTRL_SET_ENABLE];
   assign swClearEnable = wrCtrl && hwdata[CTRL_CLEAR_ENABLE];
   assign resetStart = swStartReset && !resetDrive;
   assign resumeStart = !resumeBusy && portSuspended_r && !resetDrive &&
      (swStartResume || remoteWakeEvt);

   // Overcurrent pin through three flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ovcMeta_r <= 1'b0;
         ovcSync_r <= 1'b0;
         ovcInd_r <= 1'b0;
      end else begin
         ovcMeta_r <= overcurrentPin;
         ovcSync_r <= ovcMeta_r;
         ovcInd_r <= ovcSync_r;
      end
   end

   // indicator edges, one flop after the synchroniser
   assign ovcRise = ovcSync_r && !ovcInd_r;
   assign ovcChange = ovcSync_r != ovcInd_r;

   assign hwDisable = portEnabled_r &&
      (portErrorEvt || (perPortOvc_r && ovcRise));

   // Reset or a hardware disable cuts a resume short
   assign resumeAbort = resetStart || hwDisable;

   // Port enable state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         portEnabled_r <= 1'b0;
      end else if (hwDisable || resetStart) begin
         portEnabled_r <= 1'b0;
      end else if (resetDone) begin
         portEnabled_r <= 1'b1;
      end else if (swClearEnable) begin
         portEnabled_r <= 1'b0;
      end else if (swSetEnable) begin
         portEnabled_r <= 1'b1;
      end
   end

   // Suspend state, left when resume completes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         portSuspended_r <= 1'b0;
      end else if (resumeDone || resetStart || hwDisable) begin
         portSuspended_r <= 1'b0;
      end else if (swSuspend && portEnabled_r) begin
         portSuspended_r <= 1'b1;
      end
   end

   rhpc_reset_seq #(
      .RESET_LEN(RESET_LEN)
   ) resetSeq (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(resetStart),
      .resetDrive_r(resetDrive),
      .resetDone_r(resetDone)
   );

   rhpc_resume_seq #(
      .RESUME_LEN(RESUME_LEN),
      .EOP_LEN(EOP_CYCLES),
      .RESYNC_LEN(RESYNC_LEN)
   ) resumeSeq (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(resumeStart),
      .abort(resumeAbort),
      .resumeDrive_r(resumeDrive),
      .eopDrive_r(eopDrive),
      .busy_r(resumeBusy),
      .resumeDone_r(resumeDone)
   );

   // Hardware set events
   always_comb begin
      setEvt.portEnableChangeFlag = hwDisable;
      setEvt.resumeCompleteFlag = resumeDone;
      setEvt.overcurrentChangeFlag = perPortOvc_r && ovcChange;
      setEvt.resetCompleteFlag = resetDone;
   end

   always_comb begin
      clrReq = '0;
      if (wrFlags) begin
         clrReq = hwdata[3:0];
      end
      if (resetDone) begin
         clrReq.resumeCompleteFlag = 1'b1;
      end
   end

   assign flags_nxt = setEvt | (flags_r & ~clrReq);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Level interrupt from unmasked flags
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags_nxt & mask_r);
      end
   end

   // Port line drive, one register behind the sequencers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         portDrive <= '0;
      end else begin
         portDrive.resetDrive <= resetDrive;
         portDrive.resumeDrive <= resumeDrive;
         portDrive.eopDrive <= eopDrive;
      end
   end

   // Registered port enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         portEnabledState <= 1'b0;
      end else begin
         portEnabledState <= portEnabled_r;
      end
   end

   // Registered overcurrent indicator
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         portOvercurrentIndicatorA <= 1'b0;
      end else begin
         portOvercurrentIndicatorA <= ovcInd_r;
      end
   end

   // hsize is accepted but unused: only word transfers are mapped
   logic unusedSize;
   assign unusedSize = ^hsize;
endmodule

// ==== logic/rhpc_reset_seq.sv ====
// Port reset signalling timer
`timescale 1ns/1ps
module rhpc_reset_seq #(
   parameter int RESET_LEN = rhpc_pkg::RESET_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   // Status
   output logic resetDrive_r,
   output logic resetDone_r
);
   import rhpc_pkg::*;

   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resetDrive_r <= 1'b0;
         cnt_r <= '0;
      end else if (resetDrive_r) begin
         if (cnt_r == CNT_W'(RESET_LEN - 1)) begin
            resetDrive_r <= 1'b0;
         end
         cnt_r <= cnt_r + 1'b1;
      end else if (start) begin
         resetDrive_r <= 1'b1;
         cnt_r <= '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resetDone_r <= 1'b0;
      end else begin
         resetDone_r <= resetDrive_r && (cnt_r == CNT_W'(RESET_LEN - 1));
      end
   end
endmodule

// ==== logic/rhpc_resume_seq.sv ====
// Resume sequencer: K pulse, low-speed end of packet, resync delay
`timescale 1ns/1ps
module rhpc_resume_seq #(
   parameter int RESUME_LEN = rhpc_pkg::RESUME_CYCLES,
   parameter int EOP_LEN = rhpc_pkg::EOP_CYCLES,
   parameter int RESYNC_LEN = rhpc_pkg::RESYNC_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   input wire logic abort,
   // Status
   output logic resumeDrive_r,
   output logic eopDrive_r,
   output logic busy_r,
   output logic resumeDone_r
);
   import rhpc_pkg::*;

   rhpc_resume_st_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic last;

   always_comb begin
      last = 1'b0;
      case (state_r)
         RES_K: last = (cnt_r == CNT_W'(RESUME_LEN - 1));
         RES_EOP: last = (cnt_r == CNT_W'(EOP_LEN - 1));
         RES_SYNC: last = (cnt_r == CNT_W'(RESYNC_LEN - 1));
         default: last = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= RES_IDLE;
         cnt_r <= '0;
      end else if (abort) begin
         state_r <= RES_IDLE;
         cnt_r <= '0;
      end else begin
         cnt_r <= last ? '0 : cnt_r + 1'b1;
         case (state_r)
            RES_IDLE: begin
               cnt_r <= '0;
               if (start) begin
                  state_r <= RES_K;
               end
            end
            RES_K: if (last) begin
               state_r <= RES_EOP;
            end
            RES_EOP: if (last) begin
               state_r <= RES_SYNC;
            end
            RES_SYNC: if (last) begin
               state_r <= RES_IDLE;
            end
            default: state_r <= RES_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resumeDone_r <= 1'b0;
         resumeDrive_r <= 1'b0;
         eopDrive_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         resumeDone_r <= !abort && state_r == RES_SYNC && last;
         resumeDrive_r <= !abort && ((state_r == RES_K && !last) ||
            (state_r == RES_IDLE && start));
         eopDrive_r <= !abort && ((state_r == RES_EOP && !last) ||
            (state_r == RES_K && last));
         busy_r <= !abort && (state_r != RES_IDLE || start) &&
            !(state_r == RES_SYNC && last);
      end
   end
endmodule

// ==== verification/rhpc_port_flags_asserts.sv ====
// Pin-level assertions for the port change flag block
`timescale 1ns/1ps
module rhpc_port_flags_asserts #(
   parameter int RESET_LEN = 20,
   parameter int RESUME_LEN = 30
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Bus response
   input wire logic hreadyout,
   input wire logic hresp,
   // Port side
   input wire logic portErrorEvt,
   input wire logic overcurrentPin,
   input wire rhpc_pkg::rhpc_drive_t portDrive,
   input wire logic portEnabledState,
   input wire logic portOvercurrentIndicatorA
);
   import rhpc_pkg::*;
   int rstCnt_r;
   int resCnt_r;
   int eopCnt_r;
   // Lengths of the drive pulses
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstCnt_r <= 0;
         resCnt_r <= 0;
         eopCnt_r <= 0;
      end else begin
         rstCnt_r <= portDrive.resetDrive ? rstCnt_r + 1 : 0;
         resCnt_r <= portDrive.resumeDrive ? resCnt_r + 1 : 0;
         eopCnt_r <= portDrive.eopDrive ? eopCnt_r + 1 : 0;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
      else $error("bus not ready or not okay");
   a_reset_len: assert property (
      $fell(portDrive.resetDrive) |-> rstCnt_r == RESET_LEN)
      else $error("reset signalling length wrong");
   a_reset_enable: assert property (
      $fell(portDrive.resetDrive) |-> ##[0:2] portEnabledState)
      else $error("port not enabled after reset");
   a_eop_order: assert property (
      $rose(portDrive.eopDrive) |->
         $fell(portDrive.resumeDrive) && resCnt_r == RESUME_LEN)
      else $error("end of packet not after full resume pulse");
   a_eop_len: assert property (
      $fell(portDrive.eopDrive) |-> (eopCnt_r == EOP_CYCLES) or
         (##[0:1] (portDrive.resetDrive || !portEnabledState)))
      else $error("end of packet length wrong");
   a_resync_quiet: assert property (
      $fell(portDrive.eopDrive) |-> !portDrive.resumeDrive [*8])
      else $error("resume drive during resync");
   a_hw_disable: assert property (
      portErrorEvt && portEnabledState |-> ##2 !portEnabledState)
      else $error("port error did not disable port");
   a_ovc_sync: assert property (
      $rose(overcurrentPin) |-> ##4 portOvercurrentIndicatorA)
      else $error("overcurrent indicator did not follow pin");
endmodule

// ==== verification/rhpc_usb_dev.sv ====
// Behavioural downstream device: wake, port error, overcurrent
`timescale 1ns/1ps
module rhpc_usb_dev (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Bench commands
   input wire logic wakeReq,
   input wire logic errReq,
   input wire logic ovcReq,
   input wire logic [7:0] wakeDly,
   // Toward the port
   output logic remoteWakeEvt,
   output logic portErrorEvt,
   output logic overcurrentPin
);
   logic wakePrev_r;
   logic errPrev_r;
   logic wakeArm_r;
   logic [7:0] wakeCnt_r;
   // Wake answers wakeDly+1 cycles after the request edge, so slow devices are modelled
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wakePrev_r <= 1'b0;
         errPrev_r <= 1'b0;
         wakeArm_r <= 1'b0;
         wakeCnt_r <= 8'h00;
         remoteWakeEvt <= 1'b0;
         portErrorEvt <= 1'b0;
         overcurrentPin <= 1'b0;
      end else begin
         wakePrev_r <= wakeReq;
         errPrev_r <= errReq;
         portErrorEvt <= errReq && !errPrev_r;
         overcurrentPin <= ovcReq;
         remoteWakeEvt <= 1'b0;
         if (wakeReq && !wakePrev_r) begin
            wakeArm_r <= 1'b1;
            wakeCnt_r <= wakeDly;
         end else if (wakeArm_r && wakeCnt_r == 8'h00) begin
            wakeArm_r <= 1'b0;
            remoteWakeEvt <= 1'b1;
         end else if (wakeArm_r) begin
            wakeCnt_r <= wakeCnt_r - 8'h01;
         end
      end
   end
endmodule

// ==== verification/tb_rhpc_port_flags.sv ====
// Self-checking bench for the root hub port change flags
`timescale 1ns/1ps
module tb_rhpc_port_flags;
   import rhpc_pkg::*;
   localparam int T_RST = 20;
   localparam int T_RES = 30;
   localparam int T_SYNC = 10;
   localparam logic [31:0] MODE = 32'h00000020;
   logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, x;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic wakeReq, errReq, ovcReq, remoteWakeEvt, portErrorEvt;
   logic overcurrentPin, portEnabledState, portOvercurrentIndicatorA;
   rhpc_drive_t portDrive;
   int bad_count, samples_checked, n;

   rhpc_port_flags #(.RESET_LEN(T_RST), .RESUME_LEN(T_RES),
      .RESYNC_LEN(T_SYNC)) u_rhpc_port_flags (.mclk, .rst_n, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .portErrorEvt, .remoteWakeEvt,
      .overcurrentPin, .portDrive, .portEnabledState,
      .portOvercurrentIndicatorA, .irq);
   rhpc_usb_dev u_rhpc_usb_dev (.mclk, .rst_n, .wakeReq, .errReq,
      .ovcReq, .wakeDly(8'h05), .remoteWakeEvt, .portErrorEvt,
      .overcurrentPin);

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic waitRdy;
      int k;
      k = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 100) begin
            bad_count++;
            results;
         end
         @(posedge mclk);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      waitRdy;
      hsel <= 1'b0;
      htrans <= HTRANS_IDLE;
      hwdata <= d;
      waitRdy;
      x = hrdata;
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      xfer(a, 1'b0, 32'h00000000);
      chk(nm, e, x);
   endtask
   task automatic waitIrq;
      n = 0;
      while (irq !== 1'b1) begin
         @(posedge mclk);
         n++;
         if (n > 2000) begin
            bad_count++;
            results;
         end
      end
   endtask

   initial begin
      rst_n = 1'b0;
      {hsel, hwrite, wakeReq, errReq, ovcReq} = 5'h00;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = HTRANS_IDLE;
      hsize = 3'h2;
      bad_count = 0;
      samples_checked = 0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      // Reset values, unmapped place, port reset
      chk("irq", 32'h0, {31'h0, irq});
      rd("flags", FLAGS_OFS, 32'h0);
      rd("mask", MASK_OFS, 32'h0);
      rd("ctrl", CTRL_OFS, MODE);
      xfer(8'h10, 1'b1, 32'hFFFFFFFF);
      rd("unmapped", 8'h10, 32'h0);
      xfer(MASK_OFS, 1'b1, 32'h8);
      xfer(CTRL_OFS, 1'b1, MODE | 32'h1);
      waitIrq;
      chk("reset time", 32'h1, {31'h0, n >= T_RST && n <= T_RST + 4});
      rd("flags", FLAGS_OFS, 32'h8);
      rd("state", STATE_OFS, 32'h1);
      xfer(FLAGS_OFS, 1'b1, 32'h0);
      rd("flags", FLAGS_OFS, 32'h8);
      xfer(FLAGS_OFS, 1'b1, 32'h8);
      rd("flags", FLAGS_OFS, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      // Software enable changes, then a remote wake resume
      xfer(CTRL_OFS, 1'b1, MODE | 32'h10);
      rd("state", STATE_OFS, 32'h0);
      rd("flags", FLAGS_OFS, 32'h0);
      xfer(CTRL_OFS, 1'b1, MODE | 32'h8);
      xfer(CTRL_OFS, 1'b1, MODE | 32'h2);
      rd("state", STATE_OFS, 32'h3);
      xfer(MASK_OFS, 1'b1, 32'h2);
      wakeReq <= 1'b1;
      waitIrq;
      wakeReq <= 1'b0;
      chk("resume time", 32'h1, {31'h0, n >= T_RES + EOP_CYCLES + T_SYNC
         && n <= T_RES + EOP_CYCLES + T_SYNC + 15});
      rd("flags", FLAGS_OFS, 32'h2);
      // Reset completion with the resume flag still set
      xfer(MASK_OFS, 1'b1, 32'h8);
      xfer(CTRL_OFS, 1'b1, MODE | 32'h1);
      waitIrq;
      rd("flags", FLAGS_OFS, 32'h8);
      xfer(FLAGS_OFS, 1'b1, 32'h8);
      // Hardware disable, then an event meeting a clear
      xfer(MASK_OFS, 1'b1, 32'h1);
      errReq <= 1'b1;
      waitIrq;
      errReq <= 1'b0;
      rd("flags", FLAGS_OFS, 32'h1);
      rd("state", STATE_OFS, 32'h0);
      xfer(CTRL_OFS, 1'b1, MODE | 32'h8);
      errReq <= 1'b1;
      xfer(FLAGS_OFS, 1'b1, 32'h1);
      errReq <= 1'b0;
      rd("flags", FLAGS_OFS, 32'h1);
      xfer(FLAGS_OFS, 1'b1, 32'h1);
      // Overcurrent in both directions, masking, global mode
      xfer(CTRL_OFS, 1'b1, MODE | 32'h8);
      xfer(MASK_OFS, 1'b1, 32'h4);
      ovcReq <= 1'b1;
      waitIrq;
      rd("flags", FLAGS_OFS, 32'h5);
      rd("state", STATE_OFS, 32'h10);
      xfer(FLAGS_OFS, 1'b1, 32'h5);
      rd("flags", FLAGS_OFS, 32'h0);
      ovcReq <= 1'b0;
      waitIrq;
      rd("flags", FLAGS_OFS, 32'h4);
      xfer(MASK_OFS, 1'b1, 32'h0);
      repeat (2) @(posedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
      xfer(FLAGS_OFS, 1'b1, 32'h4);
      xfer(CTRL_OFS, 1'b1, 32'h0);
      ovcReq <= 1'b1;
      repeat (6) @(posedge mclk);
      rd("flags", FLAGS_OFS, 32'h0);
      rd("ctrl", CTRL_OFS, 32'h0);
      results;
   end
endmodule

bind rhpc_port_flags rhpc_port_flags_asserts #(.RESET_LEN(RESET_LEN),
   .RESUME_LEN(RESUME_LEN)) u_rhpc_port_flags_asserts (.mclk, .rst_n,
   .hreadyout, .hresp, .portErrorEvt, .overcurrentPin, .portDrive,
   .portEnabledState, .portOvercurrentIndicatorA);
